// ==== src/port_readback_self_test.sv ====
// General-purpose I/O ports with key-enabled read-back self-diagnostic mode.
// Assumes an APB master on mclk and pin levels already synchronous to mclk;
// the power controller reports sleep or idle on a plain level input.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module port_readback_self_test
  import gpio_readback_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                            mclk,
  input  wire logic                            rst,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [ADDR_WIDTH-1:0]           paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in,
  output logic      [NUM_PORTS*PORT_WIDTH-1:0] pin_out,
  output logic      [NUM_PORTS*PORT_WIDTH-1:0] pin_oe_n,
  output logic      [NUM_PORTS*PORT_WIDTH-1:0] an_path_en,
  input  wire logic                            sleep_idle,
  output logic                                 wake_req,
  output logic                                 readback_mode_flag
);

  localparam int NPINS = NUM_PORTS * PORT_WIDTH;

  // ==========================================================================
  // Elaboration checks
  // The bit command carries a two-bit port index and the channel field five
  // bits, so more ports than that cannot be reached.
  if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and MAX_PORTS.");
  end

  // ==========================================================================
  // Storage
  logic [7:0]              self_test_key_r;
  logic                    mode_r;
  logic [ADC_CH_WIDTH-1:0] adc_ch_r;
  logic [7:0]              wake_en_r;
  logic [7:0]              pa_prev_r;
  logic [NPINS-1:0]        latch_r;
  logic [NPINS-1:0]        dir_r;
  logic [NPINS-1:0]        ansel_r;
  logic [NPINS-1:0]        port_rd;
  logic [31:0]             prdata_r;
  logic                    pready_r;
  logic                    pslverr_r;
  logic [NPINS-1:0]        pin_out_r;
  logic [NPINS-1:0]        pin_oe_n_r;
  logic [NPINS-1:0]        an_path_r;
  logic                    wake_r;

  // ==========================================================================
  // Address decode
  logic       setup;
  logic       wr_en;
  logic       port_hit;
  logic [1:0] port_idx;
  logic [3:0] port_reg;
  logic       hit;
  logic [31:0] rd_nxt;

  // Setup phase samples the read value; the write lands at the access edge.
  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pready_r && pwrite && !pslverr_r;
  assign port_idx = paddr[5:4];
  assign port_reg = paddr[3:0];
  assign port_hit = (paddr[11:6] == PORT_BLOCK_SEL) &&
                    ({30'h0000_0000, port_idx} < NUM_PORTS);

  // ==========================================================================
  // Read path through the per-bit selector
  port_read_mux #(
    .WIDTH (NPINS)
  ) u_read_mux (
    .latch    (latch_r),
    .dir      (dir_r),
    .ansel    (ansel_r),
    .pin      (pin_in),
    .readback (mode_r),
    .rd       (port_rd)
  );

  // Read data selection; unmapped offsets read zero and flag an error.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr == OFF_KEY) begin
      rd_nxt[7:0] = self_test_key_r;
    end else if (paddr == OFF_ADC_CH) begin
      rd_nxt[ADC_CH_WIDTH-1:0] = adc_ch_r;
    end else if (paddr == OFF_BITOP) begin
      rd_nxt = 32'h0000_0000;
    end else if (paddr == OFF_WAKE_EN) begin
      rd_nxt[7:0] = wake_en_r;
    end else if (paddr == OFF_STATUS) begin
      rd_nxt[STAT_MODE_BIT]  = mode_r;
      rd_nxt[STAT_SLEEP_BIT] = sleep_idle;
    end else if (port_hit && port_reg == OFF_DATA) begin
      rd_nxt[7:0] = port_rd[port_idx*PORT_WIDTH +: PORT_WIDTH];
    end else if (port_hit && port_reg == OFF_DIR) begin
      rd_nxt[7:0] = dir_r[port_idx*PORT_WIDTH +: PORT_WIDTH];
    end else if (port_hit && port_reg == OFF_ANSEL) begin
      rd_nxt[7:0] = ansel_r[port_idx*PORT_WIDTH +: PORT_WIDTH];
    end else begin
      hit = 1'b0;
    end
  end

  // ==========================================================================
  // APB response
  // The answer is prepared at the setup edge, so every transfer completes in
  // its first access cycle with no wait states.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !hit;
      if (setup && !pwrite) begin
        prdata_r <= rd_nxt;
      end else if (setup) begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Key register and mode flag
  // The flag is a flop updated with the key, so a read set up after the
  // key write completes already sees the new mode.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      self_test_key_r <= KEY_RESET;
      mode_r          <= 1'b0;
    end else if (wr_en && paddr == OFF_KEY) begin
      self_test_key_r <= pwdata[7:0];
      mode_r          <= (pwdata[7:0] == KEY_PATTERN);
    end
  end

  // ==========================================================================
  // Converter channel select and Port A wake enables
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      adc_ch_r  <= ADC_CH_RESET;
      wake_en_r <= WAKE_EN_RESET;
    end else if (wr_en && paddr == OFF_ADC_CH) begin
      adc_ch_r  <= pwdata[ADC_CH_WIDTH-1:0];
    end else if (wr_en && paddr == OFF_WAKE_EN) begin
      wake_en_r <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Bit set/clear command
  bitop_t     cmd;
  logic [7:0] rmw_src;
  logic [7:0] rmw_byte;
  logic       bitop_wr;

  // The whole port is read first, so an input pin in a data bit command
  // gets its current level copied into the latch; software must expect it.
  always_comb begin
    cmd      = bitop_t'(pwdata[BITOP_WIDTH-1:0]);
    bitop_wr = wr_en && (paddr == OFF_BITOP) &&
               ({30'h0000_0000, cmd.port} < NUM_PORTS);
    if (cmd.target) begin
      rmw_src = dir_r[cmd.port*PORT_WIDTH +: PORT_WIDTH];
    end else begin
      rmw_src = port_rd[cmd.port*PORT_WIDTH +: PORT_WIDTH];
    end
    rmw_byte              = rmw_src;
    rmw_byte[cmd.bit_idx] = cmd.value;
  end

  // ==========================================================================
  // Per-port data latch, direction and analog select
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic sel_w;
    logic rmw_hit;

    assign sel_w   = wr_en && port_hit && (port_idx == 2'(p));
    assign rmw_hit = bitop_wr && (cmd.port == 2'(p));

    // Data latch; the reset value makes a fresh output drive high.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        latch_r[p*PORT_WIDTH +: PORT_WIDTH] <= PORT_RESET;
      end else if (sel_w && port_reg == OFF_DATA) begin
        latch_r[p*PORT_WIDTH +: PORT_WIDTH] <= pwdata[7:0];
      end else if (rmw_hit && !cmd.target) begin
        latch_r[p*PORT_WIDTH +: PORT_WIDTH] <= rmw_byte;
      end
    end

    // Direction control; one means input.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        dir_r[p*PORT_WIDTH +: PORT_WIDTH] <= PORT_RESET;
      end else if (sel_w && port_reg == OFF_DIR) begin
        dir_r[p*PORT_WIDTH +: PORT_WIDTH] <= pwdata[7:0];
      end else if (rmw_hit && cmd.target) begin
        dir_r[p*PORT_WIDTH +: PORT_WIDTH] <= rmw_byte;
      end
    end

    // Analog function select for each pin of the port.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ansel_r[p*PORT_WIDTH +: PORT_WIDTH] <= 8'h00;
      end else if (sel_w && port_reg == OFF_ANSEL) begin
        ansel_r[p*PORT_WIDTH +: PORT_WIDTH] <= pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Pin drive and analog path, one flop per pin
  // Outputs follow their registers one cycle later; this keeps every pin
  // glitch free at the cost of a single clock of latency.
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        pin_out_r[i]  <= 1'b1;
        pin_oe_n_r[i] <= 1'b1;
        an_path_r[i]  <= 1'b0;
      end else begin
        pin_out_r[i]  <= latch_r[i];
        pin_oe_n_r[i] <= dir_r[i] || (ansel_r[i] && !mode_r);
        an_path_r[i]  <= ansel_r[i] ||
                         (mode_r && ({27'h000_0000, adc_ch_r} == i));
      end
    end
  end

  // ==========================================================================
  // Port A wake-up
  // The previous levels reset high, so a pin held low at reset release
  // looks like a falling edge in the first cycle; the wake enables reset to zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_prev_r <= 8'hFF;
      wake_r    <= 1'b0;
    end else begin
      pa_prev_r <= pin_in[PORT_WIDTH-1:0];
      wake_r    <= sleep_idle &&
                   |(pa_prev_r & ~pin_in[PORT_WIDTH-1:0] & wake_en_r);
    end
  end

  // ==========================================================================
  // Output connections
  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign pin_out            = pin_out_r;
  assign pin_oe_n           = pin_oe_n_r;
  assign an_path_en         = an_path_r;
  assign wake_req           = wake_r;
  assign readback_mode_flag = mode_r;

endmodule
`default_nettype wire

// ==== src/gpio_readback_pkg.sv ====
// Constants, field layouts and carrier types shared by the port read-back logic.
// Assumes a single 40 MHz system clock and an APB master with 32-bit data.
package gpio_readback_pkg;

  // ==========================================================================
  // Port geometry and reset values
  localparam int          PORT_WIDTH     = 8;
  localparam int          MAX_PORTS      = 4;
  localparam int          ADC_CH_WIDTH   = 5;
  localparam logic [7:0]  PORT_RESET     = 8'hFF;
  localparam logic [7:0]  KEY_RESET      = 8'h00;
  localparam logic [7:0]  KEY_PATTERN    = 8'hCA;
  localparam logic [7:0]  WAKE_EN_RESET  = 8'h00;
  localparam logic [4:0]  ADC_CH_RESET   = 5'h00;

  // ==========================================================================
  // Register map, byte addresses
  localparam int          ADDR_WIDTH     = 12;
  localparam logic [11:0] OFF_KEY        = 12'h000;
  localparam logic [11:0] OFF_ADC_CH     = 12'h004;
  localparam logic [11:0] OFF_BITOP      = 12'h008;
  localparam logic [11:0] OFF_WAKE_EN    = 12'h00C;
  localparam logic [11:0] OFF_STATUS     = 12'h010;
  localparam logic [5:0]  PORT_BLOCK_SEL = 6'h01;
  localparam logic [3:0]  OFF_DATA       = 4'h0;
  localparam logic [3:0]  OFF_DIR        = 4'h4;
  localparam logic [3:0]  OFF_ANSEL      = 4'h8;

  // ==========================================================================
  // Status register fields
  localparam int          STAT_MODE_BIT  = 0;
  localparam int          STAT_SLEEP_BIT = 1;

  // ==========================================================================
  // Bit set/clear command, carried in the low bits of the written word.
  localparam int          BITOP_WIDTH    = 7;
  typedef struct packed {
    logic       target;  // 0: data latch, 1: direction control.
    logic       value;   // 1: set the bit, 0: clear it.
    logic [1:0] port;
    logic [2:0] bit_idx;
  } bitop_t;

endpackage

// ==== src/port_read_mux.sv ====
// Per-bit selection of the value that a port data read returns.
// Assumes pin levels are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module port_read_mux #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] ansel,
  input  wire logic [WIDTH-1:0] pin,
  input  wire logic             readback,
  output logic      [WIDTH-1:0] rd
);

  // ==========================================================================
  // Read value per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    // One bit of the read path; analog pins read zero unless read-back is on.
    always_comb begin
      if (readback) begin
        rd[i] = pin[i];
      end else if (ansel[i]) begin
        rd[i] = 1'b0;
      end else begin
        rd[i] = dir[i] ? pin[i] : latch[i];
      end
    end
  end

endmodule
`default_nettype wire

// ==== tb/port_readback_self_test_monitor.sv ====
// Checker for the port read-back block, bound to the top module's ports.
// Assumes one clock, mclk, and the asynchronous active-high reset rst.
`timescale 1ns/1ps
`default_nettype none
module port_readback_self_test_monitor
  import gpio_readback_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  input wire logic                            mclk,
  input wire logic                            rst,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [ADDR_WIDTH-1:0]           paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_out,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_oe_n,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] an_path_en,
  input wire logic                            sleep_idle,
  input wire logic                            wake_req,
  input wire logic                            readback_mode_flag
);
  // ==========================================================================
  // Helpers
  // A completed write access is the only legal cause of a state change.
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite && pready;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Assertions
  // The flag follows the key written, from the edge after the write.
  flag_set_a: assert property (wr_acc && paddr == OFF_KEY |=>
    readback_mode_flag == ($past(pwdata[7:0]) == KEY_PATTERN)) else $error("mode flag wrong");
  flag_hold_a: assert property ($changed(readback_mode_flag) |->
    $past(wr_acc && paddr == OFF_KEY)) else $error("mode flag moved without key write");
  // Pin registers lag their cause by one cycle, so two cycles are allowed.
  drive_cause_a: assert property ($changed(pin_out) |->
    $past(wr_acc) || $past(wr_acc, 2)) else $error("pin drive changed without write");
  oe_cause_a: assert property ($changed(pin_oe_n) |->
    $past(wr_acc) || $past(wr_acc, 2)) else $error("pin enable changed without write");
  analog_cause_a: assert property ($changed(an_path_en) |->
    $past(wr_acc) || $past(wr_acc, 2)) else $error("analog path changed without write");
  reset_pins_a: assert property ($fell(rst) |->
    pin_oe_n == '1 && pin_out == '1 && !readback_mode_flag) else $error("reset pin state wrong");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  key_width_a: assert property (pready && !pwrite && paddr == OFF_KEY |->
    prdata[31:8] == '0) else $error("key read upper bits set");
  // Wake needs a Port A high-to-low step seen two or three samples back.
  wake_cause_a: assert property (wake_req |->
    (|($past(pin_in[7:0], 2) & ~$past(pin_in[7:0]))) ||
    (|($past(pin_in[7:0], 3) & ~$past(pin_in[7:0], 2)))) else $error("wake without fall");
endmodule

bind port_readback_self_test port_readback_self_test_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .an_path_en(an_path_en), .sleep_idle(sleep_idle),
  .wake_req(wake_req), .readback_mode_flag(readback_mode_flag));
`default_nettype wire

// ==== tb/pin_partner.sv ====
// External circuitry model that resolves the level on every port pin.
// Assumes the bench supplies the level outside parts put on released pins.
`timescale 1ns/1ps
`default_nettype none
module pin_partner #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe_n,
  input  wire logic [W-1:0] ext_lvl,
  output logic      [W-1:0] pin_in
);
  // ==========================================================================
  // Pin resolution
  // outside level rules released pins only
  // A released pin shows the outside level, which the bench changes often.
  assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// ==== tb/tb_port_readback_self_test.sv ====
// Self-checking bench comparing the port read-back block with a bench model.
// Assumes the package constants and the pin partner model.
`timescale 1ns/1ps
`default_nettype none
module tb_port_readback_self_test
  import gpio_readback_pkg::*;
;
  logic        mclk, rst, psel, penable, pwrite, sleep_idle, pready, pslverr, wake_req, flag, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ext_bus, pin_in, pin_out, pin_oe_n, an_path_en;
  int          n_fail, n_checks;
  logic [7:0]  lat [4], dir [4], ans [4], ext [4], key, wen;
  logic [4:0]  ch;

  port_readback_self_test #(.NUM_PORTS(4)) dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .an_path_en(an_path_en), .sleep_idle(sleep_idle),
    .wake_req(wake_req), .readback_mode_flag(flag));
  pin_partner #(.W(32)) u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_bus),
    .pin_in(pin_in));

  // ==========================================================================
  // Model
  // Expected enables, pin levels and read values per port.
  function automatic logic [7:0] oen(int p);
    return dir[p] | (ans[p] & ~{8{key == KEY_PATTERN}});
  endfunction
  function automatic logic [7:0] lvl(int p);
    return (oen(p) & ext[p]) | (~oen(p) & lat[p]);
  endfunction
  function automatic logic [7:0] rdx(int p);
    if (key == KEY_PATTERN) return lvl(p);
    return ~ans[p] & ((dir[p] & lvl(p)) | (~dir[p] & lat[p]));
  endfunction
  function automatic logic [31:0] exts();
    return {ext[3], ext[2], ext[1], ext[0]};
  endfunction

  // ==========================================================================
  // Tasks
  // Counts every comparison and reports a difference at once.
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One APB transfer, then an idle cycle so pins settle before the next one.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Reads every port and checks pins, analog paths, flag and key.
  task automatic verify();
    logic [31:0] q, oe, an;
    for (int p = 0; p < 4; p++) begin
      oe[p*8+:8] = oen(p);
      for (int i = 0; i < 8; i++) an[p*8+i] = ans[p][i] | (key == KEY_PATTERN && ch == 5'(p*8+i));
      apb(1'b0, {PORT_BLOCK_SEL, 2'(p), OFF_DATA}, 32'h0, q);
      check(q, {24'h0, rdx(p)});
    end
    check(pin_oe_n, oe);
    check(pin_out, {lat[3], lat[2], lat[1], lat[0]});
    check(an_path_en, an);
    check({31'h0, flag}, {31'h0, key == KEY_PATTERN});
    apb(1'b0, OFF_KEY, 32'h0, q);
    check(q, {24'h0, key});
  endtask
  task automatic results();
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and tests
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // The tests need under two thousand cycles; a hang stops far beyond that.
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    results();
  end
  initial begin
    logic [31:0] q, d;
    bitop_t b;
    int p, k, c;
    rst = 1'b1;
    {psel, penable, pwrite, sleep_idle, paddr, pwdata, n_fail, n_checks} = '0;
    void'($urandom(32'he7d8b236));
    {key, wen, ch} = {KEY_RESET, WAKE_EN_RESET, ADC_CH_RESET};
    for (int i = 0; i < 4; i++)
      {lat[i], dir[i], ans[i], ext[i]} = {PORT_RESET, PORT_RESET, 8'h00, 8'($urandom)};
    ext_bus = exts();
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check(pin_out, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, {PORT_BLOCK_SEL, 2'(i), OFF_DIR}, 32'h0, q);
      check(q, 32'hFF);
    end
    verify();
    apb(1'b1, {PORT_BLOCK_SEL, 2'd1, OFF_DIR}, 32'h0, q);
    dir[1] = 8'h00;
    // The pin registers move at the edge the task ends on, so look one edge later.
    @(posedge mclk);
    check({24'h0, pin_out[15:8]}, 32'hFF);
    check({24'h0, pin_oe_n[15:8]}, 32'h0);
    // random register traffic; port offsets are 0, 4 and 8
    repeat (80) begin
      p = $urandom_range(3);
      k = $urandom_range(5);
      d = {24'h0, 8'($urandom)};
      if (k < 3) begin
        apb(1'b1, {PORT_BLOCK_SEL, 2'(p), 4'(k * 4)}, d, q);
        if (k == 0) lat[p] = d[7:0];
        else if (k == 1) dir[p] = d[7:0];
        else ans[p] = d[7:0];
      end else if (k == 3) begin
        d[7:0] = $urandom_range(1) ? KEY_PATTERN : KEY_PATTERN ^ (8'h01 << $urandom_range(7));
        apb(1'b1, OFF_KEY, d, q);
        key = d[7:0];
      end else if (k == 4) begin
        apb(1'b1, OFF_ADC_CH, d, q);
        ch = d[4:0];
      end else begin
        b = bitop_t'(d[6:0]);
        apb(1'b1, OFF_BITOP, {25'h0, b}, q);
        if (b.target) dir[b.port][b.bit_idx] = b.value;
        else lat[b.port] = rdx(b.port) & ~(8'h01 << b.bit_idx) | (8'(b.value) << b.bit_idx);
      end
      ext[p] = 8'($urandom);
      ext_bus <= exts();
      @(posedge mclk);
      verify();
    end
    // Unmapped address reads zero with an error response.
    apb(1'b0, 12'hFFC, 32'h0, q);
    check(q, 32'h0);
    check({31'h0, err}, 32'h1);
    {key, dir[0], ans[0], wen} = {KEY_RESET, 8'hFF, 8'h00, 8'($urandom) | 8'h01};
    apb(1'b1, OFF_KEY, {24'h0, key}, q);
    apb(1'b1, {PORT_BLOCK_SEL, 2'd0, OFF_DIR}, 32'hFF, q);
    apb(1'b1, {PORT_BLOCK_SEL, 2'd0, OFF_ANSEL}, 32'h0, q);
    apb(1'b1, OFF_WAKE_EN, {24'h0, wen}, q);
    ext[0] = 8'hFF;
    ext_bus <= exts();
    sleep_idle <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 16; i++) begin
      if (i == 8) sleep_idle <= 1'b0;
      ext[0][i%8] = 1'b0;
      ext_bus <= exts();
      c = 0;
      repeat (4) begin
        @(posedge mclk);
        if (wake_req === 1'b1) c++;
      end
      check(32'(c), (i < 8) ? {31'h0, wen[i%8]} : 32'h0);
      ext[0][i%8] = 1'b1;
      ext_bus <= exts();
      repeat (3) @(posedge mclk);
    end
    results();
  end
endmodule
`default_nettype wire
